// ==== sar_ctrl_defs.svh ====
`ifndef SAR_CTRL_DEFS_SVH
`define SAR_CTRL_DEFS_SVH

`define RESULT_WIDTH 12
`define HALF_SCALE_CODE 12'h800
`define RESULT_RESET 12'h000
`define SKIP_WINDOW_NS 25
`define CORE_PERIOD_NS 25
// least time rounds up to whole cycles, one cycle for 25ns
`define SKIP_WINDOW_CYC ((`SKIP_WINDOW_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)

`endif

// ==== sar_ctrl_pkg.sv ====
package sar_ctrl_pkg;

typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARMED,
    ST_TRIAL,
    ST_HOLD
} conv_state_e;

typedef struct packed {
    logic select_n;
    logic read_n;
} host_strobe_s;

typedef struct packed {
    logic [11:0] data;
    logic [11:0] data_oe_n;
} data_drive_s;

endpackage

// ==== sar_adc_conversion_read_control.sv ====
// Operation
// - conversion starts when select and read strobe are both low
// - start conditions ignored while a conversion runs
// - busy low from start through whole conversion
// - trial register loads half scale at start, no clock edge needed
// - top result bit decided on second falling converter-clock edge
// - keep bit if input above trial, clear otherwise, then try next bit
// - after the start load, trial register changes only on falling converter-clock edges
// - after last decision busy rises and result moves to latches
// - unaligned strobe gives 12 or 13 clock conversion
// - strobe at rising clock edge gives 12.5 cycle conversion
// - strobe at falling clock edge gives 13 cycle conversion
// - old result kept on outputs until busy returns high
// - each single host read while idle returns last result and starts new one
// - result is a twelve-bit parallel word
// - data drivers enabled only while select and read are low
// - strobe under 25ns before falling edge skips that edge
// - result coded straight binary, step full scale over 4096
`timescale 1ns/1ps
`default_nettype none
`include "sar_ctrl_defs.svh"

module sar_adc_conversion_read_control #(
    parameter int RESULT_WIDTH = `RESULT_WIDTH
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic select_n,
    input wire logic read_n,
    input wire logic conv_clock_in,
    input wire logic comparator_high,
    output logic busy,
    output logic inverted_clock_out,
    output logic [RESULT_WIDTH-1:0] result_bus,
    output logic [RESULT_WIDTH-1:0] result_bus_oe_n,
    output logic [RESULT_WIDTH-1:0] dac_trial_code
);

    // ==========================================
    // parameter check
    if (RESULT_WIDTH != `RESULT_WIDTH) begin : gen_width_check
        $error("result width must be 12");
    end

    // ==========================================
    // input synchronisers
    logic [1:0] sel_sync_r;
    logic [1:0] rd_sync_r;
    logic [1:0] clk_sync_r;
    logic [1:0] cmp_sync_r;
    logic clk_prev_r;
    logic clk_fall;
    logic clk_rise;
    logic start_cond;
    sar_ctrl_pkg::host_strobe_s strobe;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sel_sync_r <= 2'h3;
            rd_sync_r <= 2'h3;
            clk_sync_r <= 2'h0;
            cmp_sync_r <= 2'h0;
            clk_prev_r <= 1'h0;
        end else begin
            sel_sync_r <= {sel_sync_r[0], select_n};
            rd_sync_r <= {rd_sync_r[0], read_n};
            clk_sync_r <= {clk_sync_r[0], conv_clock_in};
            cmp_sync_r <= {cmp_sync_r[0], comparator_high};
            clk_prev_r <= clk_sync_r[1];
        end
    end

    assign strobe = {sel_sync_r[1], rd_sync_r[1]};
    assign clk_fall = clk_prev_r & ~clk_sync_r[1];
    assign clk_rise = ~clk_prev_r & clk_sync_r[1];
    assign start_cond = ~strobe.select_n & ~strobe.read_n;

    // ==========================================
    // conversion sequencer
    sar_ctrl_pkg::conv_state_e state_r;
    logic [RESULT_WIDTH-1:0] trial_r;
    logic [RESULT_WIDTH-1:0] bit_ptr_r;
    logic [1:0] since_start_r;
    logic done_pulse;

    function automatic logic [RESULT_WIDTH-1:0] decide_bit(
        input logic [RESULT_WIDTH-1:0] code,
        input logic [RESULT_WIDTH-1:0] ptr,
        input logic keep
    );
        return keep ? code : (code & ~ptr);
    endfunction

    assign done_pulse = (state_r == sar_ctrl_pkg::ST_TRIAL) && clk_fall && bit_ptr_r[0];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            since_start_r <= 2'h0;
        end else if (state_r == sar_ctrl_pkg::ST_ARMED && since_start_r != 2'h3) begin
            since_start_r <= since_start_r + 2'h1;
        end else if (state_r != sar_ctrl_pkg::ST_ARMED) begin
            since_start_r <= 2'h0;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r <= sar_ctrl_pkg::ST_IDLE;
            trial_r <= `RESULT_RESET;
            bit_ptr_r <= `RESULT_RESET;
        end else begin
            unique case (state_r)
                sar_ctrl_pkg::ST_IDLE: begin
                    if (start_cond) begin
                        trial_r <= `HALF_SCALE_CODE;
                        bit_ptr_r <= `HALF_SCALE_CODE;
                        state_r <= sar_ctrl_pkg::ST_ARMED;
                    end
                end
                sar_ctrl_pkg::ST_ARMED: begin
                    if (clk_fall && since_start_r >= 2'(`SKIP_WINDOW_CYC)) begin
                        state_r <= sar_ctrl_pkg::ST_TRIAL;
                    end
                end
                sar_ctrl_pkg::ST_TRIAL: begin
                    if (clk_fall) begin
                        // keep or clear bit, set next
                        trial_r <= decide_bit(trial_r, bit_ptr_r, cmp_sync_r[1])
                                   | (bit_ptr_r >> 1);
                        bit_ptr_r <= bit_ptr_r >> 1;
                        if (bit_ptr_r[0]) begin
                            state_r <= sar_ctrl_pkg::ST_HOLD;
                        end
                    end
                end
                sar_ctrl_pkg::ST_HOLD: begin
                    if (!start_cond) begin
                        state_r <= sar_ctrl_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================
    // busy and result latch
    logic [RESULT_WIDTH-1:0] latch_r;
    logic [RESULT_WIDTH-1:0] final_code;

    assign final_code = decide_bit(trial_r, bit_ptr_r, cmp_sync_r[1]);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busy <= 1'h1;
        end else if (state_r == sar_ctrl_pkg::ST_IDLE && start_cond) begin
            busy <= 1'h0;
        end else if (done_pulse) begin
            busy <= 1'h1;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            latch_r <= `RESULT_RESET;
        end else if (done_pulse) begin
            // new straight-binary code only at end
            latch_r <= final_code;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            inverted_clock_out <= 1'h1;
            dac_trial_code <= `RESULT_RESET;
        end else begin
            inverted_clock_out <= ~clk_sync_r[1];
            dac_trial_code <= (state_r == sar_ctrl_pkg::ST_IDLE && start_cond)
                              ? `HALF_SCALE_CODE : trial_r;
        end
    end

    // ==========================================
    // three-state data drivers
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            result_bus <= `RESULT_RESET;
            result_bus_oe_n <= {RESULT_WIDTH{1'b1}};
        end else begin
            result_bus <= done_pulse ? final_code : latch_r;
            result_bus_oe_n <= {RESULT_WIDTH{~start_cond}};
        end
    end

    // ==========================================
    // checks
    chk_busy_start: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_IDLE && start_cond) |=> !busy)
        else $error("busy not low after start");
    chk_no_restart: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_TRIAL && !clk_fall) |=> $stable(bit_ptr_r))
        else $error("trial restarted");
    chk_half_scale: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_IDLE && start_cond) |=> trial_r == `HALF_SCALE_CODE)
        else $error("trial not half scale");
    chk_trial_fall: assert property (@(posedge core_clk) disable iff (reset)
        !clk_fall |=> $stable(trial_r) || $past(state_r) == sar_ctrl_pkg::ST_IDLE)
        else $error("trial moved off edge");
    chk_busy_end: assert property (@(posedge core_clk) disable iff (reset)
        done_pulse |=> busy && latch_r == $past(final_code))
        else $error("end not flagged");
    chk_hold_data: assert property (@(posedge core_clk) disable iff (reset)
        (!busy && !done_pulse) |=> $stable(latch_r))
        else $error("result changed in conversion");
    chk_oe_gate: assert property (@(posedge core_clk) disable iff (reset)
        start_cond |=> result_bus_oe_n == '0)
        else $error("drivers not enabled");
    chk_oe_off: assert property (@(posedge core_clk) disable iff (reset)
        !start_cond |=> result_bus_oe_n == '1)
        else $error("drivers not released");
    chk_step_down: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_TRIAL && clk_fall) |=> bit_ptr_r == ($past(bit_ptr_r) >> 1))
        else $error("bit pointer skipped");

    // ==========================================
    // sequencer checks

    chk_start_taken: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_IDLE && start_cond) |=> state_r == sar_ctrl_pkg::ST_ARMED)
        else $error("start not taken");

    chk_restart_ignored: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_TRIAL || state_r == sar_ctrl_pkg::ST_HOLD)
        |=> state_r != sar_ctrl_pkg::ST_ARMED)
        else $error("conversion restarted");

    chk_hold_release: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_HOLD && start_cond) |=> state_r == sar_ctrl_pkg::ST_HOLD)
        else $error("left hold with strobes low");

    chk_busy_held: assert property (@(posedge core_clk) disable iff (reset)
        (!busy && !done_pulse) |=> !busy)
        else $error("busy rose early");

    chk_dac_follows: assert property (@(posedge core_clk) disable iff (reset)
        (state_r != sar_ctrl_pkg::ST_IDLE) |=> dac_trial_code == $past(trial_r))
        else $error("dac code not trial");

    chk_top_edge: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_ARMED && clk_fall
            && since_start_r >= 2'(`SKIP_WINDOW_CYC))
        |=> state_r == sar_ctrl_pkg::ST_TRIAL && bit_ptr_r == `HALF_SCALE_CODE)
        else $error("top bit edge wrong");

    chk_bit_kept: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_TRIAL && clk_fall && cmp_sync_r[1])
        |=> (trial_r & $past(bit_ptr_r)) != '0)
        else $error("bit not kept");

    chk_bit_cleared: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_TRIAL && clk_fall && !cmp_sync_r[1])
        |=> (trial_r & $past(bit_ptr_r)) == '0)
        else $error("bit not cleared");

    chk_ptr_onehot: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_TRIAL) |-> $onehot(bit_ptr_r))
        else $error("bit pointer not one-hot");

    chk_done_hold: assert property (@(posedge core_clk) disable iff (reset)
        done_pulse |=> state_r == sar_ctrl_pkg::ST_HOLD)
        else $error("no hold after end");

    chk_data_kept: assert property (@(posedge core_clk) disable iff (reset)
        (!busy && !done_pulse) |=> result_bus == $past(latch_r))
        else $error("output word changed early");

    chk_word_out: assert property (@(posedge core_clk) disable iff (reset)
        done_pulse |=> result_bus == $past(final_code))
        else $error("new word not presented");

    chk_skip_window: assert property (@(posedge core_clk) disable iff (reset)
        (state_r == sar_ctrl_pkg::ST_ARMED && since_start_r < 2'(`SKIP_WINDOW_CYC))
        |=> state_r == sar_ctrl_pkg::ST_ARMED)
        else $error("edge inside skip window used");

    // ==========================================
    // scenario covers
    cov_start: cover property (@(posedge core_clk) disable iff (reset)
        state_r == sar_ctrl_pkg::ST_IDLE && start_cond);
    cov_done: cover property (@(posedge core_clk) disable iff (reset) done_pulse);
    cov_top_kept: cover property (@(posedge core_clk) disable iff (reset)
        done_pulse && final_code[11]);
    cov_top_dropped: cover property (@(posedge core_clk) disable iff (reset)
        done_pulse && !final_code[11]);
    cov_restart_try: cover property (@(posedge core_clk) disable iff (reset)
        state_r == sar_ctrl_pkg::ST_TRIAL && start_cond);

endmodule

`default_nettype wire

// ==== host_read_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// host read cycle
module host_read_model (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic busy,
    input wire logic go,
    input wire logic wait_mode,
    output logic select_n,
    output logic read_n
);
    logic act_r;
    logic [7:0] cnt_r;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            {select_n, read_n, act_r, cnt_r} <= {1'b1, 1'b1, 1'b0, 8'h00};
        end else if (go) begin
            {select_n, read_n, act_r, cnt_r} <= {1'b0, 1'b0, 1'b1, 8'h00};
        end else if (act_r) begin
            cnt_r <= cnt_r + 8'h01;
            if (wait_mode ? (cnt_r > 8'h08 && busy) : (cnt_r == 8'h02)) begin
                {select_n, read_n, act_r} <= {1'b1, 1'b1, 1'b0};
            end
        end
    end
endmodule
`default_nettype wire

// ==== sar_adc_conversion_read_control_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_read_control_bench;
    logic core_clk, reset, conv_clock_in, comparator_high, go, wait_mode;
    logic select_n, read_n, busy, inverted_clock_out;
    logic [11:0] result_bus, result_bus_oe_n, dac_trial_code, vin, last_r;
    logic [31:0] seed, len;
    logic [3:0] div_r;
    logic [11:0] exp_q[$];
    int mismatches, checked, want_len;
    sar_adc_conversion_read_control sar_adc_conversion_read_control_inst (.core_clk, .reset,
        .select_n, .read_n, .conv_clock_in, .comparator_high, .busy, .inverted_clock_out,
        .result_bus, .result_bus_oe_n, .dac_trial_code);
    host_read_model host_read_model_inst (.core_clk, .reset, .busy, .go, .wait_mode,
        .select_n, .read_n);
    // ==========
    // clocks and analog side
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        div_r <= div_r + 4'h1;
        if (div_r[2:0] == 3'h7) conv_clock_in <= ~conv_clock_in;
        comparator_high <= (vin > dac_trial_code);
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [11:0] sar(input logic [11:0] v);
        logic [11:0] r;
        r = 12'h000;
        for (int i = 11; i >= 0; i--) begin
            if (v > (r | (12'h001 << i))) r = r | (12'h001 << i);
        end
        return r;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 400) mismatches++;
    endtask
    // ==========
    // one read with conversion
    task automatic conv(input logic [11:0] v, input logic m, input logic again,
        input logic [1:0] al);
        @(posedge core_clk);
        // strobe falls with the rising (1) or falling (2) converter edge
        while (al != 2'h0 && div_r != ((al == 2'h1) ? 4'h6 : 4'hE)) begin
            @(posedge core_clk);
        end
        // 12.5 or 13 converter clocks of 16 core cycles
        want_len = (al == 2'h1) ? 200 : ((al == 2'h2) ? 208 : 0);
        vin <= v;
        wait_mode <= m;
        go <= 1'b1;
        exp_q.push_back(sar(v));
        @(posedge core_clk);
        go <= 1'b0;
        wait_busy(1'b0);
        check(result_bus_oe_n, 12'h000);
        check(result_bus, last_r);
        if (again) begin
            repeat (40) @(posedge core_clk);
            go <= 1'b1;
            @(posedge core_clk);
            go <= 1'b0;
            repeat (5) @(negedge core_clk);
            check(result_bus_oe_n, 12'h000);
            check(busy, 1'b0);
        end
        wait_busy(1'b1);
        if (m) check(result_bus_oe_n, 12'h000);
        repeat (6) @(negedge core_clk);
        check(result_bus_oe_n, 12'hFFF);
        $display("conversion of %h done", v);
    endtask
    // ==========
    // result monitor
    initial begin
        last_r = 12'h000;
        forever begin
            @(negedge busy);
            len = 0;
            @(negedge core_clk);
            check(dac_trial_code, 12'h800);
            check(result_bus, last_r);
            while (busy === 1'b0 && len < 400) begin
                @(negedge core_clk);
                len++;
            end
            @(negedge core_clk);
            if (want_len == 0) begin
                check((len >= 32'd192) && (len <= 32'd210), 1'b1);
            end else begin
                check(len, want_len);
            end
            check(exp_q.size(), 1);
            if (exp_q.size() > 0) last_r = exp_q.pop_front();
            check(result_bus, last_r);
        end
    end
    initial begin
        repeat (12000) @(posedge core_clk);
        mismatches++;
        results();
    end
    initial begin
        {reset, conv_clock_in, comparator_high, go, wait_mode} = 5'b10000;
        {vin, div_r, mismatches, checked} = 0;
        seed = 32'h54d5;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        repeat (3) @(posedge core_clk);
        conv(12'h000, 1'b1, 1'b0, 2'h0);
        conv(12'hFFF, 1'b0, 1'b0, 2'h0);
        conv(12'h800, 1'b0, 1'b1, 2'h0);
        // strobe falls 200ns before the next falling edge
        conv(12'h5A3, 1'b0, 1'b0, 2'h1);
        conv(12'h3C6, 1'b1, 1'b0, 2'h2);
        for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            conv(seed[11:0], seed[12], 1'b0, 2'h0);
        end
        repeat (20) @(posedge core_clk);
        results();
    end
endmodule
`default_nettype wire
